//--- cbia_pkg.sv
// Purpose: shared constants for the processor bus interface and arbiter
// Assumes: 125 MHz system clock
// Notes: address map and timing figures
package cbia_pkg;
   localparam int          CLK_PERIOD_NS     = 8;
   localparam int          RESET_MIN_NS      = 20;
   localparam int          RESET_MIN_CYC     = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          BUS_CLK_KHZ       = 12440;
   localparam int          SYS_CLK_KHZ       = 125000;
   // half period of the unstretched bus clock, in system cycles
   localparam int          BUS_HALF_CYC      = SYS_CLK_KHZ / (2 * BUS_CLK_KHZ);
   localparam int          NUM_CS            = 6;
   localparam int          NUM_DMA           = 8;
   localparam int          CS_AREA_BITS      = 24;
   localparam logic [7:0]  CS_AREA_BASE_0    = 8'h00;
   localparam logic [7:0]  CS_AREA_BASE_1    = 8'h01;
   localparam logic [7:0]  CS_AREA_BASE_2    = 8'h02;
   localparam logic [7:0]  CS_AREA_BASE_3    = 8'h03;
   localparam logic [7:0]  CS_AREA_BASE_4    = 8'h04;
   localparam logic [7:0]  CS_AREA_BASE_5    = 8'h05;
   localparam logic [31:0] SEQ_STEP          = 32'h0000_0004;
   typedef enum logic [1:0] {
      CBIA_OWN_NONE = 2'b00,
      CBIA_OWN_CPU  = 2'b01,
      CBIA_OWN_LCD  = 2'b10,
      CBIA_OWN_DMA  = 2'b11
   } cbia_owner_e;
   typedef enum logic [1:0] {
      CBIA_PWR_RUN    = 2'b00,
      CBIA_PWR_RST    = 2'b01,
      CBIA_PWR_SLEEP  = 2'b10,
      CBIA_PWR_WAKE   = 2'b11
   } cbia_pwr_e;
endpackage

//--- cbia_bus_if.sv
// Purpose: processor bus between the controller and the processor core
// Assumes: both ends on clk_in; bus clock is a level sampled by the core
// Notes: data bus is split into two one-way directions
interface cbia_bus_if;
   logic        bus_clk;
   logic        cpu_reset_low;
   logic        core_power_sleep_low;
   logic        bus_hold_off_low;
   logic        address_hold_ctrl;
   logic        next_cycle_request_low;
   logic        read_write_dir;
   logic        line_fill_flag;
   logic [1:0]  access_size;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctrl (
      output bus_clk, cpu_reset_low, core_power_sleep_low, bus_hold_off_low,
             address_hold_ctrl, rdata,
      input  next_cycle_request_low, read_write_dir, line_fill_flag, access_size,
             addr, wdata
   );
   modport cpu (
      input  bus_clk, cpu_reset_low, core_power_sleep_low, bus_hold_off_low,
             address_hold_ctrl, rdata,
      output next_cycle_request_low, read_write_dir, line_fill_flag, access_size,
             addr, wdata
   );
endinterface

//--- cbia_ctrl.sv
// Purpose: controller end: bus clock, sleep sequencing, decode, arbitration
// Assumes: core supply switch driven from supply_on_request
// Notes: all outputs registered except bus_hold_off_low and address_hold_ctrl, tied constant
// Functional notes
// - idle load stops bus clock until restart
// - sleep: reset at least 20 ns, then sleep
// - wake: supply first, then release reset, sleep; code drops sleep with the supply, then releases reset
// - processor gives full byte address, unwrapped fills
// - write lane by low address bits; code writes whole 32-bit word, ignores access_size
// - stretch only the bus clock low phase
// - processor wait input held inactive
// - request low means next cycle sequential
// - address refers to following access
// - sequential: same type, address plus four
// - non-sequential is idle then sequential cycle
// - direction stable during sequential access
// - address pipe enable kept deasserted
// - bus clock 12.44 MHz, slowable or stoppable; code divides to 12.5 MHz (half period 5 cycles)
// - data latched on bus clock falling edge
// - 32-bit data and address paths
// - six chip selects from address decode
// - boot select covers 16 MB at zero
// - second select covers external area
// - dma channel 0 highest, 7 lowest
// - dma chooses channel only when idle
// - system priority dma01, lcd, cpu, dma, cpu
module cbia_ctrl
   import cbia_pkg::*;
#(
   parameter int HALF_CYC = BUS_HALF_CYC
) (
   // clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   // processor bus
   cbia_bus_if.ctrl                 bus,
   // clock control
   input  wire logic [7:0]          clk_slow_in,
   input  wire logic [7:0]          access_stretch_in,
   input  wire logic                clk_stop_in,
   input  wire logic                idle_load_in,
   // power control
   input  wire logic                sleep_req_in,
   input  wire logic                supply_good_in,
   output logic                     supply_on_request_out,
   // memory side
   input  wire logic [31:0]         mem_rdata_in,
   output logic [NUM_CS-1:0]        chip_sel_out,
   output logic [31:0]              mem_wdata_out,
   output logic                     mem_write_out,
   output logic                     mem_strobe_out,
   // arbitration
   input  wire logic [NUM_DMA-1:0]  dma_req_in,
   input  wire logic [NUM_DMA-1:0]  dma_en_in,
   input  wire logic                dma_done_in,
   input  wire logic                lcd_req_in,
   input  wire logic                cpu_req_in,
   output logic [1:0]               grant_owner_out,
   output logic [2:0]               dma_chan_out
);
   // bus clock generator
   logic        clk_ff, nxt_clk;
   logic [9:0]  cnt_ff, nxt_cnt;
   logic        stopped_ff, nxt_stopped;
   logic        fall;
   always_comb begin
      nxt_clk     = clk_ff;
      nxt_cnt     = cnt_ff;
      nxt_stopped = stopped_ff;
      fall        = 1'b0;
      if (idle_load_in || clk_stop_in) begin
         nxt_stopped = 1'b1;
      end else if (!clk_stop_in && !idle_load_in) begin
         nxt_stopped = 1'b0;
      end
      if (!stopped_ff || clk_ff) begin
         if (clk_ff) begin
            if (cnt_ff >= 10'(HALF_CYC - 1)) begin
               nxt_clk = 1'b0;
               nxt_cnt = '0;
               fall    = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + 10'h001;
            end
         end else if (!stopped_ff) begin
            // only low phase holds the stretch and slow-down
            if (cnt_ff >= 10'(HALF_CYC - 1) + 10'(clk_slow_in) + 10'(access_stretch_in)) begin
               nxt_clk = 1'b1;
               nxt_cnt = '0;
            end else begin
               nxt_cnt = cnt_ff + 10'h001;
            end
         end
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_ff     <= 1'b0;
         cnt_ff     <= '0;
         stopped_ff <= 1'b0;
      end else begin
         clk_ff     <= nxt_clk;
         cnt_ff     <= nxt_cnt;
         stopped_ff <= nxt_stopped;
      end
   end
   assign bus.bus_clk           = clk_ff;
   assign bus.bus_hold_off_low  = 1'b1;
   assign bus.address_hold_ctrl = 1'b0;

   // sleep sequencer
   cbia_pwr_e   pwr_ff, nxt_pwr;
   logic [3:0]  rcnt_ff, nxt_rcnt;
   logic        rst_low_ff, nxt_rst_low;
   logic        supply_ff, nxt_supply;
   logic        sg_m_ff, sg_ff;
   always_comb begin
      nxt_pwr     = pwr_ff;
      nxt_rcnt    = rcnt_ff;
      nxt_rst_low = rst_low_ff;
      nxt_supply  = supply_ff;
      case (pwr_ff)
         CBIA_PWR_RUN: begin
            if (sleep_req_in) begin
               nxt_pwr     = CBIA_PWR_RST;
               nxt_rst_low = 1'b1;
               nxt_rcnt    = '0;
            end
         end
         CBIA_PWR_RST: begin
            if (rcnt_ff >= 4'(RESET_MIN_CYC)) begin
               nxt_pwr    = CBIA_PWR_SLEEP;
               nxt_supply = 1'b0;
            end else begin
               nxt_rcnt = rcnt_ff + 4'h1;
            end
         end
         CBIA_PWR_SLEEP: begin
            if (!sleep_req_in) begin
               nxt_pwr    = CBIA_PWR_WAKE;
               nxt_supply = 1'b1;
            end
         end
         CBIA_PWR_WAKE: begin
            if (sg_ff) begin
               nxt_pwr     = CBIA_PWR_RUN;
               nxt_rst_low = 1'b0;
            end
         end
         default: nxt_pwr = CBIA_PWR_RUN;
      endcase
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwr_ff     <= CBIA_PWR_RUN;
         rcnt_ff    <= '0;
         rst_low_ff <= 1'b0;
         supply_ff  <= 1'b1;
         sg_m_ff    <= 1'b0;
         sg_ff      <= 1'b0;
      end else begin
         pwr_ff     <= nxt_pwr;
         rcnt_ff    <= nxt_rcnt;
         rst_low_ff <= nxt_rst_low;
         supply_ff  <= nxt_supply;
         sg_m_ff    <= supply_good_in;
         sg_ff      <= sg_m_ff;
      end
   end
   assign bus.cpu_reset_low        = ~rst_low_ff;
   // power-sleep input follows the power-enable output
   assign bus.core_power_sleep_low = supply_ff;
   assign supply_on_request_out    = supply_ff;

   // access tracking, decode, data lanes
   logic              req_ff, nxt_req;
   logic [31:0]       addr_ff, nxt_addr;
   logic [31:0]       prev_ff, nxt_prev;
   logic              prev_dir_ff, nxt_prev_dir;
   logic [NUM_CS-1:0] cs_ff, nxt_cs;
   logic [31:0]       wd_ff, nxt_wd;
   logic [31:0]       rd_ff, nxt_rd;
   logic              wr_ff, nxt_wr, stb_ff, nxt_stb;
   logic              seq_ok;
   always_comb begin
      nxt_req      = req_ff;
      nxt_addr     = addr_ff;
      nxt_prev     = prev_ff;
      nxt_prev_dir = prev_dir_ff;
      nxt_cs       = cs_ff;
      nxt_wd       = wd_ff;
      nxt_rd       = rd_ff;
      nxt_wr       = 1'b0;
      nxt_stb      = 1'b0;
      seq_ok       = (bus.addr == prev_ff + SEQ_STEP)
                     && (bus.read_write_dir == prev_dir_ff);
      if (fall) begin
         // request sampled now describes the next cycle
         nxt_req  = ~bus.next_cycle_request_low;
         nxt_addr = bus.addr;
         nxt_cs   = '0;
         case (bus.addr[31:CS_AREA_BITS])
            CS_AREA_BASE_0: nxt_cs[0] = 1'b1;
            CS_AREA_BASE_1: nxt_cs[1] = 1'b1;
            CS_AREA_BASE_2: nxt_cs[2] = 1'b1;
            CS_AREA_BASE_3: nxt_cs[3] = 1'b1;
            CS_AREA_BASE_4: nxt_cs[4] = 1'b1;
            CS_AREA_BASE_5: nxt_cs[5] = 1'b1;
            default:        nxt_cs    = '0;
         endcase
         if (req_ff) begin
            // data moves only in a sequential cycle
            nxt_stb      = 1'b1;
            nxt_wr       = bus.read_write_dir;
            nxt_wd       = bus.wdata;
            nxt_rd       = mem_rdata_in;
            nxt_prev     = addr_ff;
            nxt_prev_dir = bus.read_write_dir;
            if (!seq_ok && !bus.line_fill_flag) begin
               nxt_prev = addr_ff;
            end
         end
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_ff      <= 1'b0;
         addr_ff     <= '0;
         prev_ff     <= '0;
         prev_dir_ff <= 1'b0;
         cs_ff       <= '0;
         wd_ff       <= '0;
         rd_ff       <= '0;
         wr_ff       <= 1'b0;
         stb_ff      <= 1'b0;
      end else begin
         req_ff      <= nxt_req;
         addr_ff     <= nxt_addr;
         prev_ff     <= nxt_prev;
         prev_dir_ff <= nxt_prev_dir;
         cs_ff       <= nxt_cs;
         wd_ff       <= nxt_wd;
         rd_ff       <= nxt_rd;
         wr_ff       <= nxt_wr;
         stb_ff      <= nxt_stb;
      end
   end
   assign bus.rdata     = rd_ff;
   assign chip_sel_out  = cs_ff;
   assign mem_wdata_out = wd_ff;
   assign mem_write_out = wr_ff;
   assign mem_strobe_out = stb_ff;

   // memory arbitration
   cbia_owner_e own_ff, nxt_own;
   logic [2:0]  ch_ff, nxt_ch;
   logic        dma_busy_ff, nxt_dma_busy;
   logic        dma_recent_ff, nxt_dma_recent;
   logic        pick_ok;
   logic [2:0]  pick;
   always_comb begin
      pick    = '0;
      pick_ok = 1'b0;
      for (int i = NUM_DMA - 1; i >= 0; i--) begin
         if (dma_req_in[i]) begin
            pick    = 3'(i);
            pick_ok = 1'b1;
         end
      end
      nxt_ch         = ch_ff;
      nxt_dma_busy   = dma_busy_ff && !dma_done_in;
      nxt_dma_recent = dma_busy_ff;
      nxt_own        = CBIA_OWN_NONE;
      if (!dma_busy_ff && pick_ok) begin
         nxt_ch = pick;
      end
      if (pick_ok && !dma_busy_ff && dma_en_in[0] && dma_en_in[1]) begin
         nxt_own = CBIA_OWN_DMA;
      end else if (lcd_req_in) begin
         nxt_own = CBIA_OWN_LCD;
      end else if (cpu_req_in && (dma_busy_ff || dma_recent_ff)) begin
         nxt_own = CBIA_OWN_CPU;
      end else if (pick_ok && !dma_busy_ff) begin
         nxt_own = CBIA_OWN_DMA;
      end else if (cpu_req_in) begin
         nxt_own = CBIA_OWN_CPU;
      end
      if (nxt_own == CBIA_OWN_DMA) begin
         nxt_dma_busy = 1'b1;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         own_ff        <= CBIA_OWN_NONE;
         ch_ff         <= '0;
         dma_busy_ff   <= 1'b0;
         dma_recent_ff <= 1'b0;
      end else begin
         own_ff        <= nxt_own;
         ch_ff         <= nxt_ch;
         dma_busy_ff   <= nxt_dma_busy;
         dma_recent_ff <= nxt_dma_recent;
      end
   end
   assign grant_owner_out = own_ff;
   assign dma_chan_out    = ch_ff;
endmodule // cbia_ctrl

//--- cbia_cpu.sv
// Purpose: processor end: drives pipelined request, address and data
// Assumes: bus clock sampled as a level on clk_in
// Notes: one access at a time from the user port
module cbia_cpu
   import cbia_pkg::*;
(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // processor bus
   cbia_bus_if.cpu           bus,
   // user access port
   input  wire logic         acc_valid_in,
   input  wire logic         acc_write_in,
   input  wire logic         acc_fill_in,
   input  wire logic [1:0]   acc_size_in,
   input  wire logic [31:0]  acc_addr_in,
   input  wire logic [31:0]  acc_wdata_in,
   output logic              acc_ready_out,
   output logic              acc_done_out,
   output logic [31:0]       acc_rdata_out
);
   logic        bc_ff, req_ff, nxt_req, busy_ff, nxt_busy, dir_ff, nxt_dir;
   logic        fill_ff, nxt_fill, done_ff, nxt_done, pend_ff, nxt_pend;
   logic [1:0]  size_ff, nxt_size;
   logic [31:0] a_ff, nxt_a, wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic        fall, rising;
   always_comb begin
      fall     = bc_ff && !bus.bus_clk;
      rising   = !bc_ff && bus.bus_clk;
      nxt_req  = req_ff;
      nxt_busy = busy_ff;
      nxt_dir  = dir_ff;
      nxt_fill = fill_ff;
      nxt_size = size_ff;
      nxt_a    = a_ff;
      nxt_wd   = wd_ff;
      nxt_rd   = rd_ff;
      nxt_done = 1'b0;
      nxt_pend = pend_ff;
      if (!busy_ff && acc_valid_in && bus.cpu_reset_low) begin
         nxt_busy = 1'b1;
         nxt_a    = acc_addr_in;
         nxt_dir  = acc_write_in;
         nxt_fill = acc_fill_in;
         nxt_size = acc_size_in;
         nxt_wd   = acc_wdata_in;
      end
      if (busy_ff && !pend_ff && rising) begin
         nxt_req = 1'b1;
      end
      if (fall && req_ff && !pend_ff) begin
         nxt_req  = 1'b0;
         nxt_pend = 1'b1;
      end else if (fall && pend_ff) begin
         nxt_pend = 1'b0;
         nxt_busy = 1'b0;
         nxt_done = 1'b1;
         nxt_rd   = bus.rdata;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bc_ff   <= 1'b0;
         req_ff  <= 1'b0;
         busy_ff <= 1'b0;
         dir_ff  <= 1'b0;
         fill_ff <= 1'b0;
         size_ff <= '0;
         a_ff    <= '0;
         wd_ff   <= '0;
         rd_ff   <= '0;
         done_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else begin
         bc_ff   <= bus.bus_clk;
         req_ff  <= nxt_req;
         busy_ff <= nxt_busy;
         dir_ff  <= nxt_dir;
         fill_ff <= nxt_fill;
         size_ff <= nxt_size;
         a_ff    <= nxt_a;
         wd_ff   <= nxt_wd;
         rd_ff   <= nxt_rd;
         done_ff <= nxt_done;
         pend_ff <= nxt_pend;
      end
   end
   assign bus.next_cycle_request_low = ~req_ff;
   assign bus.addr           = a_ff;
   assign bus.read_write_dir = dir_ff;
   assign bus.line_fill_flag = fill_ff;
   assign bus.access_size    = size_ff;
   assign bus.wdata          = wd_ff;
   assign acc_ready_out      = ~busy_ff;
   assign acc_done_out       = done_ff;
   assign acc_rdata_out      = rd_ff;
endmodule // cbia_cpu

//--- cbia_bus_assertions.sv
// Purpose: concurrent checks on the processor bus between both ends
// Assumes: single clock domain clk_in, reset rst_n_in active low
// Notes: sees interface signals only, instantiated beside the interface
module cbia_bus_assertions
   import cbia_pkg::*;
#(
   parameter int HALF_CYC = BUS_HALF_CYC
) (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   // controller driven
   input wire logic        bus_clk,
   input wire logic        cpu_reset_low,
   input wire logic        core_power_sleep_low,
   input wire logic        bus_hold_off_low,
   input wire logic        address_hold_ctrl,
   input wire logic [31:0] rdata,
   // processor driven
   input wire logic        next_cycle_request_low,
   input wire logic        read_write_dir,
   input wire logic        line_fill_flag,
   input wire logic [1:0]  access_size,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] hi_cnt_ff;
   logic [15:0] lo_cnt_ff;
   logic [15:0] nxt_hi_cnt;
   logic [15:0] nxt_lo_cnt;
   // phase length counters
   always_comb begin
      nxt_hi_cnt = bus_clk ? hi_cnt_ff + 16'h0001 : 16'h0000;
      nxt_lo_cnt = bus_clk ? 16'h0000 : lo_cnt_ff + 16'h0001;
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hi_cnt_ff <= 16'h0000;
         lo_cnt_ff <= 16'h0000;
      end else begin
         hi_cnt_ff <= nxt_hi_cnt;
         lo_cnt_ff <= nxt_lo_cnt;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_hold_off_high: assert property (bus_hold_off_low)
      else $error("wait input driven active");
   a_pipe_en_low: assert property (!address_hold_ctrl)
      else $error("address pipe enable asserted");
   a_high_phase_len: assert property ($fell(bus_clk) |-> hi_cnt_ff == 16'(HALF_CYC))
      else $error("bus clock high phase length wrong");
   a_low_phase_min: assert property ($rose(bus_clk) |-> lo_cnt_ff >= 16'(HALF_CYC))
      else $error("bus clock low phase too short");
   a_sleep_needs_reset: assert property (!core_power_sleep_low |-> !cpu_reset_low)
      else $error("sleep asserted without processor reset");
   a_reset_before_sleep: assert property ($fell(core_power_sleep_low) |->
      !$past(cpu_reset_low, 1) && !$past(cpu_reset_low, 2) && !$past(cpu_reset_low, 3))
      else $error("processor reset too short before sleep");
   a_wake_supply_first: assert property ($rose(cpu_reset_low) |->
      core_power_sleep_low && $past(core_power_sleep_low))
      else $error("reset released before supply restored");
   a_rdata_low_phase: assert property ($changed(rdata) |-> !bus_clk)
      else $error("read data changed during bus clock high");
   c_bus_clk_rise: cover property ($rose(bus_clk));
   c_sleep_entry: cover property ($fell(core_power_sleep_low));
   c_wake_exit: cover property ($rose(cpu_reset_low));
   c_request: cover property ($fell(next_cycle_request_low));
endmodule // cbia_bus_assertions

//--- test_cpu_bus_interface_arbiter.sv
// Purpose: self-checking bench joining the controller and processor ends
// Assumes: 125 MHz clk_in, inputs driven 1 ns after the rising edge
// Notes: memory results checked against a queue of notes
module test_cpu_bus_interface_arbiter;
   import cbia_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic               clk_in = 1'h0;
   logic               rst_n_in = 1'h0;
   logic [7:0]         clk_slow_in = 8'h00;
   logic [7:0]         access_stretch_in = 8'h00;
   logic               clk_stop_in = 1'h0;
   logic               idle_load_in = 1'h0;
   logic               sleep_req_in = 1'h0;
   logic               supply_good_in = 1'h1;
   logic               supply_on_request_out;
   logic [31:0]        mem_rdata_in = 32'h0;
   logic [NUM_CS-1:0]  chip_sel_out;
   logic [31:0]        mem_wdata_out;
   logic               mem_write_out;
   logic               mem_strobe_out;
   logic [NUM_DMA-1:0] dma_req_in = 8'h00;
   logic [NUM_DMA-1:0] dma_en_in = 8'h00;
   logic               dma_done_in = 1'h0;
   logic               lcd_req_in = 1'h0;
   logic               cpu_req_in = 1'h0;
   logic [1:0]         grant_owner_out;
   logic [2:0]         dma_chan_out;
   logic               acc_valid_in = 1'h0;
   logic               acc_write_in = 1'h0;
   logic [31:0]        acc_addr_in = 32'h0;
   logic [31:0]        acc_wdata_in = 32'h0;
   logic               acc_ready_out;
   logic               acc_done_out;
   logic [31:0]        acc_rdata_out;
   logic [15:0]        lfsr = 16'h0028;
   logic [38:0]        mem_q[$];
   logic [32:0]        rd_q[$];
   logic [38:0]        note;
   logic [32:0]        rnote;
   int                 error_cnt = 0;
   int                 comparisons = 0;
   localparam int      HALF_CYC_T = BUS_HALF_CYC;
   always #4 clk_in = ~clk_in;
   cbia_bus_if bus_if ();
   cbia_ctrl cbia_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus_if.ctrl),
      .clk_slow_in(clk_slow_in), .access_stretch_in(access_stretch_in),
      .clk_stop_in(clk_stop_in), .idle_load_in(idle_load_in), .sleep_req_in(sleep_req_in),
      .supply_good_in(supply_good_in), .supply_on_request_out(supply_on_request_out),
      .mem_rdata_in(mem_rdata_in), .chip_sel_out(chip_sel_out), .mem_wdata_out(mem_wdata_out),
      .mem_write_out(mem_write_out), .mem_strobe_out(mem_strobe_out), .dma_req_in(dma_req_in),
      .dma_en_in(dma_en_in), .dma_done_in(dma_done_in), .lcd_req_in(lcd_req_in),
      .cpu_req_in(cpu_req_in), .grant_owner_out(grant_owner_out), .dma_chan_out(dma_chan_out));
   cbia_cpu cbia_cpu_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus_if.cpu),
      .acc_valid_in(acc_valid_in), .acc_write_in(acc_write_in), .acc_fill_in(1'h0),
      .acc_size_in(2'h2), .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in),
      .acc_ready_out(acc_ready_out), .acc_done_out(acc_done_out), .acc_rdata_out(acc_rdata_out));
   cbia_bus_assertions cbia_bus_assertions_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .bus_clk(bus_if.bus_clk), .cpu_reset_low(bus_if.cpu_reset_low),
      .core_power_sleep_low(bus_if.core_power_sleep_low), .rdata(bus_if.rdata),
      .bus_hold_off_low(bus_if.bus_hold_off_low), .address_hold_ctrl(bus_if.address_hold_ctrl),
      .next_cycle_request_low(bus_if.next_cycle_request_low), .addr(bus_if.addr),
      .read_write_dir(bus_if.read_write_dir), .line_fill_flag(bus_if.line_fill_flag),
      .access_size(bus_if.access_size), .wdata(bus_if.wdata));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic end_sim();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cpu_access(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      logic [NUM_CS-1:0] cs;
      int                i;
      cs = (addr[31:24] < 8'h06) ? 6'h01 << addr[26:24] : 6'h00;
      lfsr = lfsr_next(lfsr);
      mem_rdata_in = {lfsr, ~lfsr};
      i = 0;
      while (acc_ready_out !== 1'h1 && i < 200) begin
         tick(1);
         i++;
      end
      mem_q.push_back({cs, wr, data});
      rd_q.push_back({~wr, lfsr, ~lfsr});
      acc_valid_in = 1'h1;
      acc_write_in = wr;
      acc_addr_in = addr;
      acc_wdata_in = data;
      tick(1);
      acc_valid_in = 1'h0;
      i = 0;
      while (acc_done_out !== 1'h1 && i < 200) begin
         tick(1);
         i++;
      end
      tick(1);
   endtask
   task automatic measure_low(output int n);
      int i;
      i = 0;
      while (bus_if.bus_clk !== 1'h1 && i < 300) begin
         tick(1);
         i++;
      end
      while (bus_if.bus_clk === 1'h1 && i < 600) begin
         tick(1);
         i++;
      end
      n = 0;
      while (bus_if.bus_clk === 1'h0 && n < 300) begin
         tick(1);
         n++;
      end
   endtask
   // result monitor
   always @(posedge clk_in) begin
      if (rst_n_in && mem_strobe_out === 1'h1) begin
         note = (mem_q.size() > 0) ? mem_q.pop_front() : '1;
         chk_val("chip_sel", 32'(note[38:33]), 32'(chip_sel_out));
         chk_val("mem_write", 32'(note[32]), 32'(mem_write_out));
         if (note[32]) chk_val("mem_wdata", note[31:0], mem_wdata_out);
      end
      if (rst_n_in && acc_done_out === 1'h1 && rd_q.size() > 0) begin
         rnote = rd_q.pop_front();
         if (rnote[32]) chk_val("acc_rdata", rnote[31:0], acc_rdata_out);
      end
   end
   initial begin
      #400000;
      error_cnt++;
      end_sim();
   end
   initial begin
      int          n;
      int          hi;
      int          ch;
      logic [1:0]  own;
      tick(16);
      rst_n_in = 1'h1;
      tick(4);
      // every area plus an unmapped one, then a sequential follow-on read
      for (int a = 0; a < 7; a++) begin
         lfsr = lfsr_next(lfsr);
         cpu_access(1'h1, {8'(a), 8'h10, lfsr[15:2], 2'h0}, {lfsr, 16'h5AA5});
         cpu_access(1'h0, {8'(a), 8'h10, lfsr[15:2], 2'h0}, 32'h0);
         cpu_access(1'h0, {8'(a), 8'h10, lfsr[15:2], 2'h0} + SEQ_STEP, 32'h0);
      end
      // low phase stretch
      for (int k = 0; k < 3; k++) begin
         clk_slow_in = 8'(k);
         access_stretch_in = 8'(2 * k);
         tick(60);
         measure_low(n);
         chk_val("low phase", 32'(HALF_CYC_T + 3 * k), 32'(n));
      end
      clk_slow_in = 8'h00;
      access_stretch_in = 8'h00;
      // clock stop and idle load
      for (int s = 0; s < 2; s++) begin
         measure_low(n);
         while (bus_if.bus_clk === 1'h1) tick(1);
         clk_stop_in = (s == 0);
         idle_load_in = (s == 1);
         hi = 0;
         for (int c = 0; c < 40; c++) begin
            tick(1);
            hi += int'(bus_if.bus_clk === 1'h1);
         end
         chk_val("stopped clock", 32'h0, 32'(hi));
         clk_stop_in = 1'h0;
         idle_load_in = 1'h0;
         measure_low(n);
         chk_val("restart low", 32'(HALF_CYC_T), 32'(n));
      end
      // sleep entry and exit
      sleep_req_in = 1'h1;
      tick(2);
      chk_val("cpu reset", 32'h0, 32'(bus_if.cpu_reset_low));
      chk_val("early sleep", 32'h1, 32'(bus_if.core_power_sleep_low));
      tick(4);
      chk_val("sleep", 32'h0, 32'(bus_if.core_power_sleep_low));
      chk_val("supply", 32'h0, 32'(supply_on_request_out));
      supply_good_in = 1'h0;
      tick(4);
      sleep_req_in = 1'h0;
      tick(2);
      chk_val("supply", 32'h1, 32'(supply_on_request_out));
      chk_val("held reset", 32'h0, 32'(bus_if.cpu_reset_low));
      supply_good_in = 1'h1;
      tick(8);
      chk_val("cpu reset", 32'h1, 32'(bus_if.cpu_reset_low));
      // arbitration from idle with random requests
      for (int c = 0; c < 12; c++) begin
         lfsr = lfsr_next(lfsr);
         dma_req_in = lfsr[7:0];
         dma_en_in = {6'h00, lfsr[9:8]};
         lcd_req_in = lfsr[10];
         cpu_req_in = lfsr[11];
         ch = 0;
         for (int b = 7; b >= 0; b--) if (lfsr[b]) ch = b;
         own = (lfsr[7:0] != 8'h00 && lfsr[9:8] == 2'h3) ? CBIA_OWN_DMA :
               lfsr[10] ? CBIA_OWN_LCD : (lfsr[7:0] != 8'h00) ? CBIA_OWN_DMA :
               lfsr[11] ? CBIA_OWN_CPU : CBIA_OWN_NONE;
         tick(1);
         chk_val("grant", 32'(own), 32'(grant_owner_out));
         if (own == CBIA_OWN_DMA) chk_val("dma chan", 32'(ch), 32'(dma_chan_out));
         dma_req_in = 8'h00;
         lcd_req_in = 1'h0;
         cpu_req_in = 1'h0;
         dma_done_in = 1'h1;
         tick(1);
         dma_done_in = 1'h0;
         tick(4);
      end
      // busy dma keeps its channel and yields to the processor
      dma_req_in = 8'h04;
      cpu_req_in = 1'h1;
      tick(1);
      chk_val("dma chan", 32'h2, 32'(dma_chan_out));
      dma_req_in = 8'h01;
      tick(1);
      chk_val("grant", 32'(CBIA_OWN_CPU), 32'(grant_owner_out));
      tick(1);
      chk_val("dma chan", 32'h2, 32'(dma_chan_out));
      dma_done_in = 1'h1;
      tick(1);
      dma_done_in = 1'h0;
      tick(4);
      chk_val("pending notes", 32'h0, 32'(mem_q.size()));
      end_sim();
   end
endmodule // test_cpu_bus_interface_arbiter
